//--- alu_defines.svh
// Constants for the 8-bit arithmetic and logic datapath
// Functional notes
// RULE1 - Add two registers, optionally with carry in; Z C N V H; one cycle.
// RULE2 - Word add of small immediate to register pair; Z C N V S; two cycles.
// RULE3 - Subtract immediate from destination; Z C N V H; one cycle.
// RULE4 - Register subtract with borrow: dest minus source minus carry; one cycle.
// RULE5 - Immediate subtract with borrow: dest minus constant minus carry; one cycle.
// RULE6 - Word subtract of small immediate from register pair; Z C N V S; two cycles.
// RULE7 - AND with register or constant; only Z N V change, carry kept; one cycle.
// RULE8 - OR with register or constant, XOR of registers; Z N V; one cycle.
// RULE9 - Set mask bits ORs constant into destination; Z N V; one cycle.
// RULE10 - Clear mask bits ANDs with 0xFF minus mask; Z N V; one cycle.
// RULE11 - Test ANDs register with itself, value unchanged; Z N V; one cycle.
// RULE12 - Unsigned, signed, mixed multiplies write 16-bit product pair; Z C; two cycles.
// RULE13 - Fractional multiplies shift product left one bit first; Z C; two cycles.
// RULE14 - I/O bit set and clear accepted only for addresses 0x00 to 0x1F.
// RULE15 - I/O bit set and clear rewrite the whole register read.
// RULE16 - Complement, negate, increment, decrement update flags from result; one cycle.
`ifndef ALU_DEFINES_SVH
`define ALU_DEFINES_SVH

`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAGS_RESET 8'h00
`define ALL_ONES 8'hff
`define IO_BIT_LIMIT 6'h1f
`define LAT_SINGLE 1
`define LAT_DOUBLE 2

`endif

//--- alu_types_pkg.sv
// Types shared by the arithmetic and logic datapath
package alu_types_pkg;
    typedef enum logic [4:0] {
        OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUBTRACT_IMMEDIATE,
        OP_SUBTRACT_REGISTERS_WITH_BORROW, OP_SUBTRACT_IMMEDIATE_WITH_BORROW,
        OP_AND, OP_AND_WITH_CONSTANT, OP_OR, OP_OR_WITH_CONSTANT,
        OP_EXCLUSIVE_OR_REGISTERS, OP_SET_MASK_BITS, OP_CLEAR_MASK_BITS,
        OP_TEST_REGISTER, OP_ONES_COMPLEMENT, OP_TWOS_COMPLEMENT, OP_INC, OP_DEC,
        OP_WORD_ADD_IMMEDIATE, OP_WORD_SUBTRACT_IMMEDIATE,
        OP_MULTIPLY_UNSIGNED, OP_MULTIPLY_SIGNED, OP_MULTIPLY_MIXED_SIGN,
        OP_FRACTIONAL_MULTIPLY_UNSIGNED, OP_FRACTIONAL_MULTIPLY_SIGNED,
        OP_FRACTIONAL_MULTIPLY_MIXED, OP_IO_BIT_SET, OP_IO_BIT_CLEAR
    } op_t;

    typedef struct packed {
        logic [7:0] res;
        logic c;
        logic h;
        logic v;
    } arith_t;
endpackage

//--- alu_word_unit.sv
// Registered 16-bit add or subtract of a small immediate on a register pair
`timescale 1ns/100ps
`default_nettype none
module alu_word_unit #(
    parameter int IMM_W = 6
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic subtract,
    input wire logic [15:0] pair,
    input wire logic [IMM_W-1:0] imm,
    output logic valid,
    output logic [15:0] res,
    output logic c,
    output logic z,
    output logic n,
    output logic v,
    output logic s
);
    logic [16:0] full;
    logic next_v;

    always_comb begin
        if (subtract) begin
            full = {1'b0, pair} - {{(17-IMM_W){1'b0}}, imm};
            next_v = pair[15] & ~full[15];
        end else begin
            full = {1'b0, pair} + {{(17-IMM_W){1'b0}}, imm};
            next_v = ~pair[15] & full[15];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            valid <= 1'b0;
            res <= 16'h0000;
            c <= 1'b0;
            z <= 1'b0;
            n <= 1'b0;
            v <= 1'b0;
            s <= 1'b0;
        end else begin
            valid <= start;
            if (start) begin
                res <= full[15:0];
                c <= full[16];
                z <= (full[15:0] == 16'h0000);
                n <= full[15];
                v <= next_v;
                s <= full[15] ^ next_v;
            end
        end
    end
endmodule // alu_word_unit
`default_nettype wire

//--- alu_multiplier.sv
// Registered 8x8 multiplier with signed, mixed and fractional forms
`timescale 1ns/100ps
`default_nettype none
module alu_multiplier (
    input wire logic clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic a_signed,
    input wire logic b_signed,
    input wire logic frac,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    output logic valid,
    output logic [15:0] product,
    output logic c,
    output logic z
);
    logic signed [17:0] raw;
    logic [15:0] shaped;

    always_comb begin
        raw = $signed({a_signed & a[7], a}) * $signed({b_signed & b[7], b});
        // Carry is the product's top bit before the fractional shift
        shaped = frac ? {raw[14:0], 1'b0} : raw[15:0];
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            valid <= 1'b0;
            product <= 16'h0000;
            c <= 1'b0;
            z <= 1'b0;
        end else begin
            valid <= start;
            if (start) begin
                product <= shaped;
                c <= raw[15];
                z <= (shaped == 16'h0000);
            end
        end
    end
endmodule // alu_multiplier
`default_nettype wire

//--- alu_core.sv
// Arithmetic and logic datapath: one-cycle byte ops, two-cycle word and multiply ops
`timescale 1ns/100ps
`default_nettype none
`include "alu_defines.svh"
module alu_core #(
    parameter int IMM_W = 6
) (
    input wire logic CLK_SYS,
    input wire logic NRST,
    input wire logic OP_VALID,
    input wire alu_types_pkg::op_t OP_CODE,
    input wire logic [7:0] DEST_VAL,
    input wire logic [7:0] SRC_VAL,
    input wire logic [7:0] PAIR_HI,
    input wire logic [7:0] IMM,
    input wire logic [7:0] FLAGS_IN,
    input wire logic [5:0] IO_ADDR,
    input wire logic [2:0] IO_BIT,
    input wire logic [7:0] IO_RDATA,
    output logic BUSY,
    output logic DONE,
    output logic [7:0] RES_LO,
    output logic [7:0] RES_HI,
    output logic RES_PAIR,
    output logic RES_TO_PRODUCT,
    output logic [7:0] FLAGS_OUT,
    output logic IO_WRITE,
    output logic [5:0] IO_WADDR,
    output logic [7:0] IO_WDATA,
    output logic IO_REJECT
);
    logic next_busy, next_done, next_res_pair, next_res_to_product;
    logic next_io_write, next_io_reject;
    logic [7:0] next_res_lo, next_res_hi, next_flags, next_io_wdata;
    logic [5:0] next_io_waddr;
    logic [7:0] held_flags, next_held_flags;
    logic accepted, word_start, word_sub, mul_start, mul_a_signed, mul_b_signed, mul_frac;
    logic word_valid, word_c, word_z, word_n, word_v, word_s;
    logic mul_valid, mul_c, mul_z;
    logic [15:0] word_res, mul_product;

    function automatic alu_types_pkg::arith_t arith8(input logic [7:0] a, input logic [7:0] b,
                                                     input logic cin, input logic sub);
        logic [8:0] full;
        logic [4:0] half;
        alu_types_pkg::arith_t r;
        if (sub) begin
            full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
            half = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
            r.v = (a[7] & ~b[7] & ~full[7]) | (~a[7] & b[7] & full[7]);
        end else begin
            full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
            r.v = (a[7] & b[7] & ~full[7]) | (~a[7] & ~b[7] & full[7]);
        end
        r.res = full[7:0];
        r.c = full[8];
        r.h = half[4];
        return r;
    endfunction

    // Z N V from a logic result; overflow is always cleared
    function automatic logic [7:0] logic_flags(input logic [7:0] f, input logic [7:0] res);
        logic [7:0] o;
        o = f;
        o[`FLAG_Z] = (res == 8'h00);
        o[`FLAG_N] = res[7];
        o[`FLAG_V] = 1'b0;
        return o;
    endfunction

    function automatic logic [7:0] arith_flags(input logic [7:0] f, input alu_types_pkg::arith_t r,
                                               input logic keep_z);
        logic [7:0] o;
        o = f;
        // Borrow chains only clear Z, so a multi-byte compare sees the whole word
        o[`FLAG_Z] = (r.res == 8'h00) & (f[`FLAG_Z] | ~keep_z);
        o[`FLAG_C] = r.c;
        o[`FLAG_N] = r.res[7];
        o[`FLAG_V] = r.v;
        o[`FLAG_H] = r.h;
        return o;
    endfunction

    assign accepted = OP_VALID && !BUSY;

    always_comb begin
        word_start = 1'b0;
        word_sub = 1'b0;
        mul_start = 1'b0;
        mul_a_signed = 1'b0;
        mul_b_signed = 1'b0;
        mul_frac = 1'b0;
        if (accepted) begin
            case (OP_CODE)
                alu_types_pkg::OP_WORD_ADD_IMMEDIATE: word_start = 1'b1; // RULE2
                alu_types_pkg::OP_WORD_SUBTRACT_IMMEDIATE: begin
                    word_start = 1'b1; // RULE6
                    word_sub = 1'b1;
                end
                alu_types_pkg::OP_MULTIPLY_UNSIGNED: mul_start = 1'b1; // RULE12
                alu_types_pkg::OP_MULTIPLY_SIGNED: begin
                    mul_start = 1'b1;
                    mul_a_signed = 1'b1;
                    mul_b_signed = 1'b1;
                end
                alu_types_pkg::OP_MULTIPLY_MIXED_SIGN: begin
                    mul_start = 1'b1;
                    mul_a_signed = 1'b1;
                end
                alu_types_pkg::OP_FRACTIONAL_MULTIPLY_UNSIGNED: begin
                    mul_start = 1'b1; // RULE13
                    mul_frac = 1'b1;
                end
                alu_types_pkg::OP_FRACTIONAL_MULTIPLY_SIGNED: begin
                    mul_start = 1'b1;
                    mul_frac = 1'b1;
                    mul_a_signed = 1'b1;
                    mul_b_signed = 1'b1;
                end
                alu_types_pkg::OP_FRACTIONAL_MULTIPLY_MIXED: begin
                    mul_start = 1'b1;
                    mul_frac = 1'b1;
                    mul_a_signed = 1'b1;
                end
                default: ;
            endcase
        end
    end

    alu_word_unit #(.IMM_W(IMM_W)) word_unit (
        .clk(CLK_SYS),
        .nrst(NRST),
        .start(word_start),
        .subtract(word_sub),
        .pair({PAIR_HI, DEST_VAL}),
        .imm(IMM[IMM_W-1:0]),
        .valid(word_valid),
        .res(word_res),
        .c(word_c),
        .z(word_z),
        .n(word_n),
        .v(word_v),
        .s(word_s)
    );

    alu_multiplier multiplier (
        .clk(CLK_SYS),
        .nrst(NRST),
        .start(mul_start),
        .a_signed(mul_a_signed),
        .b_signed(mul_b_signed),
        .frac(mul_frac),
        .a(DEST_VAL),
        .b(SRC_VAL),
        .valid(mul_valid),
        .product(mul_product),
        .c(mul_c),
        .z(mul_z)
    );

    always_comb begin
        alu_types_pkg::arith_t ar;
        logic [7:0] lg;
        ar = '0;
        lg = 8'h00;
        next_busy = 1'b0;
        next_done = 1'b0;
        next_res_lo = RES_LO;
        next_res_hi = RES_HI;
        next_res_pair = RES_PAIR;
        next_res_to_product = RES_TO_PRODUCT;
        next_flags = FLAGS_OUT;
        next_held_flags = held_flags;
        next_io_write = 1'b0;
        next_io_reject = 1'b0;
        next_io_waddr = IO_WADDR;
        next_io_wdata = IO_WDATA;
        if (BUSY) begin
            // Second cycle: the flags taken at request time carry the untouched bits
            next_done = 1'b1;
            next_res_pair = 1'b1;
            next_flags = held_flags;
            if (word_valid) begin
                next_res_to_product = 1'b0;
                {next_res_hi, next_res_lo} = word_res; // RULE2 RULE6
                next_flags[`FLAG_C] = word_c;
                next_flags[`FLAG_Z] = word_z;
                next_flags[`FLAG_N] = word_n;
                next_flags[`FLAG_V] = word_v;
                next_flags[`FLAG_S] = word_s;
            end else begin
                next_res_to_product = 1'b1;
                {next_res_hi, next_res_lo} = mul_product; // RULE12 RULE13
                next_flags[`FLAG_C] = mul_c;
                next_flags[`FLAG_Z] = mul_z;
            end
        end else if (OP_VALID) begin
            next_done = 1'b1;
            next_res_pair = 1'b0;
            next_res_to_product = 1'b0;
            next_res_hi = 8'h00;
            case (OP_CODE)
                alu_types_pkg::OP_ADD, alu_types_pkg::OP_ADD_CARRY: begin
                    ar = arith8(DEST_VAL, SRC_VAL, (OP_CODE == alu_types_pkg::OP_ADD_CARRY)
                                & FLAGS_IN[`FLAG_C], 1'b0); // RULE1
                    next_res_lo = ar.res;
                    next_flags = arith_flags(FLAGS_IN, ar, 1'b0);
                end
                alu_types_pkg::OP_SUB, alu_types_pkg::OP_SUBTRACT_IMMEDIATE: begin
                    ar = arith8(DEST_VAL, (OP_CODE == alu_types_pkg::OP_SUB) ? SRC_VAL : IMM,
                                1'b0, 1'b1); // RULE3
                    next_res_lo = ar.res;
                    next_flags = arith_flags(FLAGS_IN, ar, 1'b0);
                end
                alu_types_pkg::OP_SUBTRACT_REGISTERS_WITH_BORROW: begin
                    ar = arith8(DEST_VAL, SRC_VAL, FLAGS_IN[`FLAG_C], 1'b1); // RULE4
                    next_res_lo = ar.res;
                    next_flags = arith_flags(FLAGS_IN, ar, 1'b1);
                end
                alu_types_pkg::OP_SUBTRACT_IMMEDIATE_WITH_BORROW: begin
                    ar = arith8(DEST_VAL, IMM, FLAGS_IN[`FLAG_C], 1'b1); // RULE5
                    next_res_lo = ar.res;
                    next_flags = arith_flags(FLAGS_IN, ar, 1'b1);
                end
                alu_types_pkg::OP_AND, alu_types_pkg::OP_AND_WITH_CONSTANT,
                alu_types_pkg::OP_OR, alu_types_pkg::OP_OR_WITH_CONSTANT,
                alu_types_pkg::OP_EXCLUSIVE_OR_REGISTERS, alu_types_pkg::OP_SET_MASK_BITS,
                alu_types_pkg::OP_CLEAR_MASK_BITS, alu_types_pkg::OP_TEST_REGISTER: begin
                    case (OP_CODE)
                        alu_types_pkg::OP_AND: lg = DEST_VAL & SRC_VAL; // RULE7
                        alu_types_pkg::OP_AND_WITH_CONSTANT: lg = DEST_VAL & IMM; // RULE7
                        alu_types_pkg::OP_OR: lg = DEST_VAL | SRC_VAL; // RULE8
                        alu_types_pkg::OP_EXCLUSIVE_OR_REGISTERS: lg = DEST_VAL ^ SRC_VAL; // RULE8
                        alu_types_pkg::OP_CLEAR_MASK_BITS: lg = DEST_VAL & (`ALL_ONES - IMM); // RULE10
                        alu_types_pkg::OP_TEST_REGISTER: lg = DEST_VAL & DEST_VAL; // RULE11
                        default: lg = DEST_VAL | IMM; // RULE8 RULE9
                    endcase
                    next_res_lo = lg;
                    next_flags = logic_flags(FLAGS_IN, lg);
                end
                alu_types_pkg::OP_ONES_COMPLEMENT: begin
                    lg = `ALL_ONES - DEST_VAL; // RULE16
                    next_res_lo = lg;
                    next_flags = logic_flags(FLAGS_IN, lg);
                    next_flags[`FLAG_C] = 1'b1;
                end
                alu_types_pkg::OP_TWOS_COMPLEMENT: begin
                    ar = arith8(8'h00, DEST_VAL, 1'b0, 1'b1); // RULE16
                    next_res_lo = ar.res;
                    next_flags = arith_flags(FLAGS_IN, ar, 1'b0);
                end
                alu_types_pkg::OP_INC, alu_types_pkg::OP_DEC: begin
                    ar = arith8(DEST_VAL, 8'h01, 1'b0, OP_CODE == alu_types_pkg::OP_DEC); // RULE16
                    next_res_lo = ar.res;
                    next_flags = logic_flags(FLAGS_IN, ar.res);
                    next_flags[`FLAG_V] = ar.v;
                end
                alu_types_pkg::OP_IO_BIT_SET, alu_types_pkg::OP_IO_BIT_CLEAR: begin
                    // Bit ops answer through the write or refusal pulse, not through DONE
                    next_done = 1'b0;
                    next_flags = FLAGS_IN;
                    if (IO_ADDR > `IO_BIT_LIMIT) begin
                        next_io_reject = 1'b1; // RULE14
                    end else begin
                        // Whole byte goes back, so any set clear-on-one flag gets cleared
                        next_io_write = 1'b1; // RULE15
                        next_io_waddr = IO_ADDR;
                        next_io_wdata = IO_RDATA;
                        next_io_wdata[IO_BIT] = (OP_CODE == alu_types_pkg::OP_IO_BIT_SET);
                    end
                end
                default: begin
                    // Two-cycle ops: hold the flags and answer on the next cycle
                    next_done = 1'b0;
                    next_busy = 1'b1;
                    next_held_flags = FLAGS_IN;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            BUSY <= 1'b0;
            DONE <= 1'b0;
            RES_LO <= 8'h00;
            RES_HI <= 8'h00;
            RES_PAIR <= 1'b0;
            RES_TO_PRODUCT <= 1'b0;
            FLAGS_OUT <= `FLAGS_RESET;
            held_flags <= `FLAGS_RESET;
            IO_WRITE <= 1'b0;
            IO_WADDR <= 6'h00;
            IO_WDATA <= 8'h00;
            IO_REJECT <= 1'b0;
        end else begin
            BUSY <= next_busy;
            DONE <= next_done;
            RES_LO <= next_res_lo;
            RES_HI <= next_res_hi;
            RES_PAIR <= next_res_pair;
            RES_TO_PRODUCT <= next_res_to_product;
            FLAGS_OUT <= next_flags;
            held_flags <= next_held_flags;
            IO_WRITE <= next_io_write;
            IO_WADDR <= next_io_waddr;
            IO_WDATA <= next_io_wdata;
            IO_REJECT <= next_io_reject;
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);

    function automatic logic is_op(input alu_types_pkg::op_t o);
        return accepted && OP_CODE == o;
    endfunction

    a_add_one_cycle: assert property (is_op(alu_types_pkg::OP_ADD_CARRY) |=> DONE && !BUSY && // RULE1
        RES_LO == $past(DEST_VAL) + $past(SRC_VAL) + {7'h00, $past(FLAGS_IN[`FLAG_C])})
        else $error("add with carry result or timing wrong");
    a_word_add_two: assert property (is_op(alu_types_pkg::OP_WORD_ADD_IMMEDIATE) |=> // RULE2
        BUSY && !DONE ##1 DONE && RES_PAIR && {RES_HI, RES_LO} == $past({PAIR_HI, DEST_VAL}, 2)
        + 16'($past(IMM[IMM_W-1:0], 2)) &&
        FLAGS_OUT[`FLAG_S] == (FLAGS_OUT[`FLAG_N] ^ FLAGS_OUT[`FLAG_V]))
        else $error("word add wrong");
    a_sub_imm_value: assert property (is_op(alu_types_pkg::OP_SUBTRACT_IMMEDIATE) |=> DONE && // RULE3
        RES_LO == $past(DEST_VAL) - $past(IMM) && FLAGS_OUT[`FLAG_C] == ($past(IMM) > $past(DEST_VAL)))
        else $error("subtract immediate wrong");
    a_borrow_reg: assert property (is_op(alu_types_pkg::OP_SUBTRACT_REGISTERS_WITH_BORROW) |=> // RULE4
        RES_LO == $past(DEST_VAL) - $past(SRC_VAL) - {7'h00, $past(FLAGS_IN[`FLAG_C])})
        else $error("register borrow subtract wrong");
    a_borrow_imm: assert property (is_op(alu_types_pkg::OP_SUBTRACT_IMMEDIATE_WITH_BORROW) |=> // RULE5
        RES_LO == $past(DEST_VAL) - $past(IMM) - {7'h00, $past(FLAGS_IN[`FLAG_C])})
        else $error("immediate borrow subtract wrong");
    a_word_sub_two: assert property (is_op(alu_types_pkg::OP_WORD_SUBTRACT_IMMEDIATE) |=> // RULE6
        !DONE ##1 DONE &&
        {RES_HI, RES_LO} == $past({PAIR_HI, DEST_VAL}, 2) - 16'($past(IMM[IMM_W-1:0], 2)))
        else $error("word subtract wrong");
    a_and_keeps_carry: assert property (is_op(alu_types_pkg::OP_AND) |=> // RULE7
        FLAGS_OUT[`FLAG_C] == $past(FLAGS_IN[`FLAG_C]) && !FLAGS_OUT[`FLAG_V] &&
        RES_LO == ($past(DEST_VAL) & $past(SRC_VAL))) else $error("and flags wrong");
    a_xor_value: assert property (is_op(alu_types_pkg::OP_EXCLUSIVE_OR_REGISTERS) |=> // RULE8
        RES_LO == ($past(DEST_VAL) ^ $past(SRC_VAL)) && FLAGS_OUT[`FLAG_Z] == (RES_LO == 8'h00))
        else $error("xor wrong");
    a_set_mask: assert property (is_op(alu_types_pkg::OP_SET_MASK_BITS) |=> // RULE9
        RES_LO == ($past(DEST_VAL) | $past(IMM))) else $error("set mask wrong");
    a_clear_mask: assert property (is_op(alu_types_pkg::OP_CLEAR_MASK_BITS) |=> // RULE10
        RES_LO == ($past(DEST_VAL) & ~$past(IMM))) else $error("clear mask wrong");
    a_test_keeps: assert property (is_op(alu_types_pkg::OP_TEST_REGISTER) |=> // RULE11
        RES_LO == $past(DEST_VAL) && FLAGS_OUT[`FLAG_N] == RES_LO[7]) else $error("test wrong");
    a_mul_product: assert property (is_op(alu_types_pkg::OP_MULTIPLY_UNSIGNED) |=> // RULE12
        !DONE ##1 DONE && RES_TO_PRODUCT && {RES_HI, RES_LO} == $past(DEST_VAL, 2) * $past(SRC_VAL, 2)
        && FLAGS_OUT[`FLAG_C] == RES_HI[7]) else $error("multiply wrong");
    a_frac_shift: assert property (is_op(alu_types_pkg::OP_FRACTIONAL_MULTIPLY_UNSIGNED) |=> // RULE13
        ##1 DONE && {RES_HI, RES_LO} == ($past(DEST_VAL, 2) * $past(SRC_VAL, 2)) << 1)
        else $error("fractional multiply wrong");
    a_io_range: assert property (is_op(alu_types_pkg::OP_IO_BIT_SET) && IO_ADDR > `IO_BIT_LIMIT // RULE14
        |=> IO_REJECT && !IO_WRITE) else $error("io bit out of range not refused");
    a_io_rmw: assert property (is_op(alu_types_pkg::OP_IO_BIT_CLEAR) && IO_ADDR <= `IO_BIT_LIMIT // RULE15
        |=> IO_WRITE && IO_WDATA == ($past(IO_RDATA) & ~(8'h01 << $past(IO_BIT))))
        else $error("io bit rewrite wrong");
    a_complement: assert property (is_op(alu_types_pkg::OP_ONES_COMPLEMENT) |=> // RULE16
        RES_LO == ~$past(DEST_VAL) && FLAGS_OUT[`FLAG_C]) else $error("complement wrong");

    c_add_carry: cover property (is_op(alu_types_pkg::OP_ADD_CARRY) ##1 FLAGS_OUT[`FLAG_H]);
    c_word_wrap: cover property (is_op(alu_types_pkg::OP_WORD_SUBTRACT_IMMEDIATE) ##2 FLAGS_OUT[`FLAG_C]);
    c_signed_mul: cover property (is_op(alu_types_pkg::OP_MULTIPLY_SIGNED) ##2 FLAGS_OUT[`FLAG_C]);
    c_io_reject: cover property (IO_REJECT);
endmodule // alu_core
`default_nettype wire

//--- test_eight_bit_arith_logic_unit.sv
// Self-checking bench for the arithmetic and logic datapath
`timescale 1ns/100ps
`default_nettype none
module test_eight_bit_arith_logic_unit;
logic clk = 0, nrst = 0, op_valid = 0;
alu_types_pkg::op_t op_code = alu_types_pkg::OP_ADD;
logic [7:0] dest = 0, src = 0, hi = 0, imm = 0, fl = 0, io_rdata = 0;
logic [7:0] res_lo, res_hi, flags, io_wdata;
logic [5:0] io_addr = 0, io_waddr;
logic [2:0] io_bit = 0;
logic busy, done, res_pair, res_prod, io_write, io_reject;
int bad_count = 0, n_checks = 0, lat;
alu_core alu_core_inst (.CLK_SYS(clk), .NRST(nrst), .OP_VALID(op_valid), .OP_CODE(op_code),
    .DEST_VAL(dest), .SRC_VAL(src), .PAIR_HI(hi), .IMM(imm), .FLAGS_IN(fl), .IO_ADDR(io_addr),
    .IO_BIT(io_bit), .IO_RDATA(io_rdata), .BUSY(busy), .DONE(done), .RES_LO(res_lo),
    .RES_HI(res_hi), .RES_PAIR(res_pair), .RES_TO_PRODUCT(res_prod), .FLAGS_OUT(flags),
    .IO_WRITE(io_write), .IO_WADDR(io_waddr), .IO_WDATA(io_wdata), .IO_REJECT(io_reject));
initial begin
    forever #5 clk = ~clk;
end
task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
        $display("== PASSED ==");
    else
        $display("== FAILED ==");
    $finish;
endtask
task automatic check(input logic [28:0] seen, input logic [28:0] want);
    n_checks++;
    if (seen !== want) begin
        bad_count++;
        $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
    end
endtask
// Packs cycle count, pair markers, 16-bit result and flags into one compare
task automatic go(input alu_types_pkg::op_t c, input logic [7:0] d, s, h, k, f,
                  input logic [28:0] want);
    // One idle edge keeps the strobe from being raised where it was just lowered
    @(negedge clk);
    op_code = c;
    {dest, src, hi, imm, fl} = {d, s, h, k, f};
    op_valid = 1;
    lat = 0;
    do begin
        @(negedge clk);
        op_valid = 0;
        lat++;
    end while (done !== 1'b1 && lat < 6);
    if (lat == 6) begin
        bad_count++;
        test_done();
    end
    check({3'(lat), res_prod, res_pair, res_hi, res_lo, flags}, want);
endtask
task automatic t_reset();
    check({3'd0, res_prod, res_pair, res_hi, res_lo, flags}, {done, 2'b00, 24'h0});
endtask
task automatic t_add();
    go(alu_types_pkg::OP_ADD, 8'h0f, 8'h01, 0, 0, 8'h00, {5'h04, 16'h0010, 8'h20});
    go(alu_types_pkg::OP_ADD_CARRY, 8'h7f, 8'h00, 0, 0, 8'h01, {5'h04, 16'h0080, 8'h2c});
    go(alu_types_pkg::OP_ONES_COMPLEMENT, 8'h55, 0, 0, 0, 8'h00, {5'h04, 16'h00aa, 8'h05});
    go(alu_types_pkg::OP_TWOS_COMPLEMENT, 8'h01, 0, 0, 0, 8'h00, {5'h04, 16'h00ff, 8'h25});
    go(alu_types_pkg::OP_INC, 8'h7f, 0, 0, 0, 8'h00, {5'h04, 16'h0080, 8'h0c});
endtask
task automatic t_sub();
    go(alu_types_pkg::OP_SUBTRACT_IMMEDIATE, 8'h00, 0, 0, 8'h01, 8'h00, {5'h04, 16'h00ff, 8'h25});
    // Zero result with old zero clear must leave zero clear
    go(alu_types_pkg::OP_SUBTRACT_REGISTERS_WITH_BORROW, 8'h05, 8'h04, 0, 0, 8'h01, {5'h04, 16'h0, 8'h00});
    go(alu_types_pkg::OP_SUBTRACT_IMMEDIATE_WITH_BORROW, 8'h10, 0, 0, 8'h00, 8'h01, {5'h04, 16'h0f, 8'h20});
endtask
task automatic t_logic();
    go(alu_types_pkg::OP_AND_WITH_CONSTANT, 8'hf0, 0, 0, 8'h0f, 8'h01, {5'h04, 16'h0, 8'h03});
    go(alu_types_pkg::OP_EXCLUSIVE_OR_REGISTERS, 8'haa, 8'haa, 0, 0, 8'h00, {5'h04, 16'h0, 8'h02});
    go(alu_types_pkg::OP_SET_MASK_BITS, 8'h01, 0, 0, 8'h80, 8'h00, {5'h04, 16'h81, 8'h04});
    go(alu_types_pkg::OP_CLEAR_MASK_BITS, 8'hff, 0, 0, 8'h0f, 8'h00, {5'h04, 16'hf0, 8'h04});
    go(alu_types_pkg::OP_TEST_REGISTER, 8'h80, 0, 0, 0, 8'h00, {5'h04, 16'h80, 8'h04});
endtask
task automatic t_pair();
    go(alu_types_pkg::OP_WORD_ADD_IMMEDIATE, 8'hff, 0, 8'h00, 8'h01, 8'h00, {5'h09, 16'h0100, 8'h00});
    go(alu_types_pkg::OP_WORD_SUBTRACT_IMMEDIATE, 8'h00, 0, 8'h00, 8'h01, 8'h00, {5'h09, 16'hffff, 8'h15});
    go(alu_types_pkg::OP_MULTIPLY_SIGNED, 8'hff, 8'h02, 0, 0, 8'h00, {5'h0b, 16'hfffe, 8'h01});
    go(alu_types_pkg::OP_FRACTIONAL_MULTIPLY_UNSIGNED, 8'h80, 8'h80, 0, 0, 8'h00, {5'h0b, 16'h8000, 8'h00});
endtask
task automatic t_io();
    @(negedge clk);
    {io_addr, io_bit, io_rdata, fl, op_code} = {6'h1f, 3'h3, 8'h81, 8'h2a, alu_types_pkg::OP_IO_BIT_SET};
    op_valid = 1;
    @(negedge clk);
    op_valid = 0;
    check({io_write, io_reject, done, io_waddr, io_wdata}, {3'b100, 6'h1f, 8'h89});
    {io_addr, io_bit, io_rdata, op_code} = {6'h00, 3'h0, 8'h03, alu_types_pkg::OP_IO_BIT_CLEAR};
    op_valid = 1;
    @(negedge clk);
    check({io_write, io_reject, io_waddr, io_wdata}, {2'b10, 6'h00, 8'h02});
    io_addr = 6'h20;
    @(negedge clk);
    op_valid = 0;
    check({io_write, io_reject, flags}, {2'b01, 8'h2a});
endtask
initial begin
    repeat (5) @(negedge clk);
    t_reset();
    nrst = 1;
    t_add();
    t_sub();
    t_logic();
    t_pair();
    t_io();
    test_done();
end
endmodule // test_eight_bit_arith_logic_unit
`default_nettype wire
